// ===== design/tppwm_regs.vh
`ifndef TPPWM_REGS_VH
`define TPPWM_REGS_VH

// Register byte offsets on the Wishbone bus
`define TPPWM_ADR_CTRL      8'h00
`define TPPWM_ADR_PERIOD    8'h04
`define TPPWM_ADR_PRESCALE  8'h08
`define TPPWM_ADR_PH_ONE    8'h0c
`define TPPWM_ADR_PH_TWO    8'h10
`define TPPWM_ADR_STATUS    8'h14

// Control register fields
`define TPPWM_CTL_W         7
`define TPPWM_CTL_EN_A      0
`define TPPWM_CTL_EN_B      1
`define TPPWM_CTL_SLAVE     2
`define TPPWM_CTL_BLANK_A   3
`define TPPWM_CTL_BLANK_B   4
`define TPPWM_CTL_COMPLEMENTARY_MODE_SELECT_LO  5
`define TPPWM_CTL_COMPLEMENTARY_MODE_SELECT_HI  6
`define TPPWM_CTL_RST       7'h00

// Phase control register fields
`define TPPWM_PH_POL        7
`define TPPWM_PH_COMPARATOR_TWO_FEEDBACK_ENABLE       6
`define TPPWM_PH_COMPARATOR_ONE_FEEDBACK_ENABLE       5
`define TPPWM_PH_CNT_HI     4
`define TPPWM_PH_RST        8'h00

// Status register fields
`define TPPWM_ST_SYNC       5
`define TPPWM_ST_OUT_A      6
`define TPPWM_ST_OUT_B      7
`define TPPWM_ST_SEEN       8

// Reset values of period and prescale, counter step and complementary-off code
`define TPPWM_PER_RST       5'h00
`define TPPWM_PRE_RST       4'h0
`define TPPWM_CNT_ONE       5'h01
`define TPPWM_COMPLEMENTARY_MODE_SELECT_OFF     2'h0

`endif

// ===== design/tppwm_prescaler.v
`timescale 1ns/1ps
// Divides ref_clk by 2**exponent into a one-cycle tick
module tppwm_prescaler #(
  parameter EXP_W = 4,
  parameter DIV_W = 16
) (
  input  wire             ref_clk,
  input  wire             nrst,
  input  wire             run,
  input  wire [EXP_W-1:0] exponent,
  output wire             tick
);

  reg  [DIV_W-1:0] div_r;
  wire [DIV_W-1:0] mask;
  wire [DIV_W-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < DIV_W; i = i + 1) begin : g_mask
      assign mask[i] = (i < exponent);
      assign hit[i]  = ~mask[i] | div_r[i];
    end
  endgenerate

  assign tick = run & (&hit);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= {DIV_W{1'b0}};
    end else if (!run) begin
      div_r <= {DIV_W{1'b0}};
    end else begin
      div_r <= div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // tppwm_prescaler

// ===== design/tppwm_top.v
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "tppwm_regs.vh"
module tppwm_top #(
  parameter PER_W = 5,
  parameter EXP_W = 4,
  parameter DIV_W = 16
) (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        comparator_one_result,
  input  wire        comparator_two_result,
  input  wire        shutdown,
  input  wire        sync_in,
  output wire        sync_out,
  output wire        sync_oe,
  output wire        phase_a_output,
  output wire        phase_b_output
);

  reg  [`TPPWM_CTL_W-1:0] ctrl_r;
  reg  [PER_W-1:0]        period_count_r;
  reg  [EXP_W-1:0]        prescale_exponent_r;
  reg  [7:0]              phase_one_control_r;
  reg  [7:0]              phase_two_control_r;
  reg  [PER_W-1:0]        cnt_r;
  reg  [PER_W-1:0]        cnt_nxt;
  reg                     seen_r;
  reg                     seen_nxt;
  reg                     sync_r;
  reg                     sync_nxt;
  wire [1:0]              act_r;
  wire [1:0]              blank_r;
  wire [1:0]              raw;
  wire [1:0]              phase_en;
  wire [1:0]              output_polarity;
  wire                    run;
  wire                    slave;
  wire                    comp_mode;
  wire                    counting;
  wire                    tick;
  wire                    bus_req;
  wire                    bus_wr;
  wire [31:0]             status;

  assign phase_en  = {ctrl_r[`TPPWM_CTL_EN_B], ctrl_r[`TPPWM_CTL_EN_A]};
  assign run       = |phase_en;
  assign slave     = ctrl_r[`TPPWM_CTL_SLAVE];
  // Only meaningful with both phases on
  assign comp_mode = (ctrl_r[`TPPWM_CTL_COMPLEMENTARY_MODE_SELECT_HI:`TPPWM_CTL_COMPLEMENTARY_MODE_SELECT_LO] != `TPPWM_COMPLEMENTARY_MODE_SELECT_OFF)
                     & (&phase_en);
  assign output_polarity       = {phase_two_control_r[`TPPWM_PH_POL], phase_one_control_r[`TPPWM_PH_POL]};

  // Wishbone slave, one wait state, ack drops after one cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];

  assign status = {23'h000000, seen_r, phase_b_output, phase_a_output, sync_r, cnt_r};

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `TPPWM_ADR_CTRL: begin
          wb_dat_o <= {25'h0000000, ctrl_r};
        end
        `TPPWM_ADR_PERIOD: begin
          wb_dat_o <= {{(32-PER_W){1'b0}}, period_count_r};
        end
        `TPPWM_ADR_PRESCALE: begin
          wb_dat_o <= {{(32-EXP_W){1'b0}}, prescale_exponent_r};
        end
        `TPPWM_ADR_PH_ONE: begin
          wb_dat_o <= {24'h000000, phase_one_control_r};
        end
        `TPPWM_ADR_PH_TWO: begin
          wb_dat_o <= {24'h000000, phase_two_control_r};
        end
        `TPPWM_ADR_STATUS: begin
          wb_dat_o <= status;
        end
        default: begin
          wb_dat_o <= 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r              <= `TPPWM_CTL_RST;
      period_count_r      <= `TPPWM_PER_RST;
      prescale_exponent_r <= `TPPWM_PRE_RST;
      phase_one_control_r <= `TPPWM_PH_RST;
      phase_two_control_r <= `TPPWM_PH_RST;
    end else if (bus_wr) begin
      case (wb_adr_i)
        `TPPWM_ADR_CTRL: begin
          ctrl_r <= wb_dat_i[`TPPWM_CTL_W-1:0];
        end
        `TPPWM_ADR_PERIOD: begin
          period_count_r <= wb_dat_i[PER_W-1:0];
        end
        `TPPWM_ADR_PRESCALE: begin
          prescale_exponent_r <= wb_dat_i[EXP_W-1:0];
        end
        `TPPWM_ADR_PH_ONE: begin
          phase_one_control_r <= wb_dat_i[7:0];
        end
        `TPPWM_ADR_PH_TWO: begin
          phase_two_control_r <= wb_dat_i[7:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  tppwm_prescaler #(
    .EXP_W (EXP_W),
    .DIV_W (DIV_W)
  ) u_prescaler (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .run      (run),
    .exponent (prescale_exponent_r),
    .tick     (tick)
  );

  // Period counter, master wrap or slave sync reset
  always @* begin
    cnt_nxt  = cnt_r;
    seen_nxt = seen_r;
    sync_nxt = sync_r;
    if (!run) begin
      cnt_nxt  = {PER_W{1'b0}};
      seen_nxt = 1'b0;
      sync_nxt = 1'b0;
    end else if (slave) begin
      sync_nxt = 1'b0;
      if (tick) begin
        if (sync_in) begin
          cnt_nxt  = {PER_W{1'b0}};
          seen_nxt = 1'b1;
        end else if (!seen_r) begin
          cnt_nxt = {PER_W{1'b0}};
        end else if (cnt_r != period_count_r) begin
          cnt_nxt = cnt_r + `TPPWM_CNT_ONE;
        end
      end
    end else if (tick) begin
      if (cnt_r >= period_count_r) begin
        cnt_nxt = {PER_W{1'b0}};
      end else begin
        cnt_nxt = cnt_r + `TPPWM_CNT_ONE;
      end
      sync_nxt = (cnt_nxt == period_count_r);
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= {PER_W{1'b0}};
      seen_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      seen_r <= seen_nxt;
      sync_r <= sync_nxt;
    end
  end

  // Master drives the shared pin, slave listens
  assign sync_out = sync_r;
  assign sync_oe  = run & ~slave;

  assign counting = ~slave | seen_nxt;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_phase
      wire [7:0] ph_ctl;
      wire       set;
      wire       blank_en;
      wire       fb;
      wire       kill;
      reg        ph_act_r;
      reg        ph_blank_r;
      assign act_r[p]   = ph_act_r;
      assign blank_r[p] = ph_blank_r;
      assign ph_ctl   = (p == 0) ? phase_one_control_r : phase_two_control_r;
      assign blank_en = (p == 0) ? ctrl_r[`TPPWM_CTL_BLANK_A] : ctrl_r[`TPPWM_CTL_BLANK_B];
      assign set      = tick & phase_en[p] & counting
                        & (cnt_nxt == ph_ctl[`TPPWM_PH_CNT_HI:0]);
      assign fb       = (ph_ctl[`TPPWM_PH_COMPARATOR_ONE_FEEDBACK_ENABLE] & comparator_one_result)
                        | (ph_ctl[`TPPWM_PH_COMPARATOR_TWO_FEEDBACK_ENABLE] & comparator_two_result);
      // Feedback ends the pulse without waiting for an edge
      assign kill     = shutdown | (fb & ~(blank_en & blank_r[p]));
      assign raw[p]   = act_r[p] & ~kill & phase_en[p];

      always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          ph_act_r   <= 1'b0;
          ph_blank_r <= 1'b0;
        end else begin
          ph_blank_r <= set & ~shutdown;
          if (!phase_en[p] || shutdown) begin
            ph_act_r <= 1'b0;
          end else if (set) begin
            ph_act_r <= 1'b1;
          end else if (kill) begin
            ph_act_r <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign phase_a_output = raw[0] ^ output_polarity[0];
  assign phase_b_output = (comp_mode ? (~raw[0] & ~shutdown) : raw[1]) ^ output_polarity[1];

endmodule // tppwm_top

// ===== verif/tppwm_assertions.sv
`timescale 1ns/1ps
`include "tppwm_regs.vh"
module tppwm_assertions (
  input wire        ref_clk,
  input wire        nrst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        shutdown,
  input wire        sync_out,
  input wire        sync_oe,
  input wire        phase_a_output,
  input wire        phase_b_output
);
  reg  pol_a_r;
  reg  pol_b_r;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  // Shadow of both polarity bits
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pol_a_r <= 1'b0;
      pol_b_r <= 1'b0;
    end else if (wr) begin
      if (wb_adr_i == `TPPWM_ADR_PH_ONE) pol_a_r <= wb_dat_i[7];
      if (wb_adr_i == `TPPWM_ADR_PH_TWO) pol_b_r <= wb_dat_i[7];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_quiet: assert property (!wb_stb_i [*2] |-> !wb_ack_o)
    else $error("ack while idle");
  a_shut_phase_a: assert property (shutdown |-> phase_a_output == pol_a_r)
    else $error("phase a active in shutdown");
  a_shut_phase_b: assert property (shutdown |-> phase_b_output == pol_b_r)
    else $error("phase b active in shutdown");
  a_sync_master: assert property ($rose(sync_out) |-> sync_oe)
    else $error("sync pulse while not driving");
  a_oe_by_write: assert property ($changed(sync_oe) |-> wb_ack_o)
    else $error("sync drive changed without write");
endmodule // tppwm_assertions

bind tppwm_top tppwm_assertions chk (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .shutdown, .sync_out, .sync_oe,
  .phase_a_output, .phase_b_output);

// ===== verif/tppwm_far_side.sv
`timescale 1ns/1ps
module tppwm_far_side (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       phase_a_output,
  input  wire       phase_b_output,
  input  wire [3:0] sense_dly,
  input  wire       sync_run,
  output reg        comparator_one_result,
  output reg        comparator_two_result,
  output reg        sync_in
);
  reg [3:0] cnt_a_r;
  reg [3:0] cnt_b_r;
  reg [4:0] mst_r;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {cnt_a_r, cnt_b_r, mst_r} <= 13'h0;
      {comparator_one_result, comparator_two_result, sync_in} <= 3'h0;
    end else begin
      // Sense trips sense_dly cycles into a drive, zero never trips
      cnt_a_r <= phase_a_output ? cnt_a_r + 4'h1 : 4'h0;
      cnt_b_r <= phase_b_output ? cnt_b_r + 4'h1 : 4'h0;
      comparator_one_result <= phase_a_output && |sense_dly && cnt_a_r >= sense_dly - 4'h1;
      comparator_two_result <= phase_b_output && |sense_dly && cnt_b_r >= sense_dly - 4'h1;
      // Master on the shared clock, prescale 0, period 3; pin pulled low when idle
      mst_r <= (mst_r == 5'h03) ? 5'h00 : mst_r + 5'h01;
      sync_in <= sync_run && mst_r == 5'h02;
    end
  end
endmodule // tppwm_far_side

// ===== verif/testbench.sv
`timescale 1ns/1ps
`include "tppwm_regs.vh"
module testbench;
  reg         ref_clk = 1'b0;
  reg         nrst = 1'b0;
  reg         wb_cyc_i = 1'b0;
  reg         wb_stb_i = 1'b0;
  reg         wb_we_i = 1'b0;
  reg  [7:0]  wb_adr_i = 8'h00;
  reg  [3:0]  wb_sel_i = 4'hf;
  reg  [31:0] wb_dat_i = 32'h0;
  reg         shutdown = 1'b0;
  reg         sync_run = 1'b0;
  reg  [3:0]  sense_dly = 4'h2;
  reg  [31:0] v;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, comparator_one_result, comparator_two_result, sync_in;
  wire        sync_out, sync_oe, phase_a_output, phase_b_output;
  wire [2:0]  obs = {sync_in, sync_out, phase_a_output};
  int         error_cnt = 0;
  int         compares = 0;
  int         n;
  int         hl;
  tppwm_top dut (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .comparator_one_result, .comparator_two_result,
    .shutdown, .sync_in, .sync_out, .sync_oe, .phase_a_output, .phase_b_output);
  // Phase pins wired straight to the power stage, as if port direction cleared
  tppwm_far_side far (.ref_clk, .nrst, .phase_a_output, .phase_b_output, .sense_dly,
    .sync_run, .comparator_one_result, .comparator_two_result, .sync_in);
  initial forever #25 ref_clk = ~ref_clk;
  task chk(input [31:0] s, input [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task bus(input w, input [3:0] s, input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, w, s, a, d};
    n = 0;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && ++n < 20);
    v = wb_dat_o;
    chk(wb_ack_o, 1'b1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, 4'hf, a, d);
  endtask
  // Edges until the chosen signal reads l, 300 when it never does
  task lvl(input int s, input l);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (obs[s] !== l && n < 300);
  endtask
  task t_regs;
    reg [7:0] a;
    for (a = 8'h00; a < 8'h20; a = a + 8'h04) begin
      bus(1'b0, 4'hf, a, 32'h0);
      chk(v, 32'h0);
    end
    bus(1'b1, 4'h0, `TPPWM_ADR_CTRL, 32'h1);
    bus(1'b0, 4'hf, `TPPWM_ADR_CTRL, 32'h0);
    chk(v, 32'h0);
  endtask
  task t_master;
    int p;
    wr(`TPPWM_ADR_PERIOD, 32'h3);
    wr(`TPPWM_ADR_PH_ONE, 32'h20);
    wr(`TPPWM_ADR_CTRL, 32'h1);
    chk(sync_oe, 1'b1);
    for (p = 0; p < 3; p++) begin
      wr(`TPPWM_ADR_PRESCALE, p);
      lvl(1, 1'b1);
      lvl(1, 1'b0);
      lvl(1, 1'b1);
      lvl(1, 1'b0);
      hl = n;
      lvl(1, 1'b1);
      chk(hl, 1 << p);
      chk(hl + n, 4 << p);
    end
    wr(`TPPWM_ADR_PRESCALE, 32'h0);
    for (p = 0; p < 3; p += 2) begin
      wr(`TPPWM_ADR_PH_ONE, 32'h20 | p);
      lvl(1, 1'b0);
      lvl(1, 1'b1);
      lvl(0, 1'b1);
      chk(n, p + 1);
    end
  endtask
  task t_slave;
    wr(`TPPWM_ADR_CTRL, 32'h0);
    wr(`TPPWM_ADR_PERIOD, 32'h7);
    wr(`TPPWM_ADR_PH_ONE, 32'h21);
    wr(`TPPWM_ADR_CTRL, 32'h5);
    chk(sync_oe, 1'b0);
    lvl(0, 1'b1);
    chk(n, 300);
    sync_run <= 1'b1;
    lvl(2, 1'b1);
    lvl(0, 1'b1);
    chk(n, 2);
    sync_run <= 1'b0;
  endtask
  task t_duty;
    wr(`TPPWM_ADR_CTRL, 32'h0);
    wr(`TPPWM_ADR_PERIOD, 32'h3);
    wr(`TPPWM_ADR_PH_ONE, 32'h0);
    wr(`TPPWM_ADR_CTRL, 32'h1);
    lvl(0, 1'b1);
    lvl(0, 1'b0);
    chk(n, 300);
    wr(`TPPWM_ADR_PH_ONE, 32'h80);
    chk(phase_a_output, 1'b0);
    shutdown <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk(phase_a_output, 1'b1);
    shutdown <= 1'b0;
  endtask
  task t_off;
    wr(`TPPWM_ADR_CTRL, 32'h0);
    chk(sync_oe, 1'b0);
    bus(1'b0, 4'hf, `TPPWM_ADR_STATUS, 32'h0);
    chk(v[4:0], 5'h00);
    wr(`TPPWM_ADR_CTRL, 32'h2);
    chk(sync_oe, 1'b1);
    lvl(1, 1'b1);
    lvl(1, 1'b0);
    chk(n, 1);
  endtask
  task t_comp;
    int h;
    wr(`TPPWM_ADR_PH_ONE, 32'h20);
    wr(`TPPWM_ADR_CTRL, 32'h23);
    h = 0;
    repeat (8) begin
      @(posedge ref_clk);
      h += phase_a_output;
      chk(phase_b_output, !phase_a_output);
    end
    chk(h > 0, 1'b1);
  endtask
  task stop_test;
    $display("Mismatches %0d of %0d comparisons", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs;
    t_master;
    t_slave;
    t_duty;
    t_off;
    t_comp;
    stop_test;
  end
  initial begin
    #1000000;
    error_cnt++;
    stop_test;
  end
endmodule // testbench
